// [hw/lebs_params.svh]
// constants for the local external bus sequencer
`ifndef LEBS_PARAMS_SVH
`define LEBS_PARAMS_SVH
`define LEBS_CS_NUM     8
`define LEBS_ADDR_W     26
`define LEBS_ADDR_HI_W  8
`define LEBS_DATA_W     32
`define LEBS_WS_W       16
`define LEBS_DC_W       4
`define LEBS_FIFO_DEPTH 8
`define LEBS_SYNC_SLACK 2
`define LEBS_HANDOVER_IPB 4
`define LEBS_BEATS_SHORT 6'h08
`define LEBS_BEATS_LONG  6'h20
`define LEBS_DSZ_8      2'h0
`define LEBS_DSZ_16     2'h1
`define LEBS_DSZ_32     2'h2
`define LEBS_RST_DATA   32'h0000_0000
`endif

// [hw/lebs_pkg.sv]
// types shared by the local external bus sequencer
package lebs_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_ALE   = 3'b010,
      ST_WAIT  = 3'b011,
      ST_BEAT  = 3'b100,
      ST_HOLD  = 3'b101,
      ST_DEAD  = 3'b110
   } lebs_state_e;
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_BURST  = 2'b01,
      MODE_MUX    = 2'b10
   } lebs_mode_e;
endpackage

// [hw/lebs_stream_if.sv]
// valid/ready stream with a slack indication for the read data path
interface lebs_stream_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic         room;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready, input room);
   modport snk (input valid, input data, output ready, output room);
endinterface

// [hw/lebs_fifo.sv]
// read data fifo with registered output word
module lebs_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8,
   parameter int SLACK = 2
) (
   input  wire logic   clock_in,
   input  wire logic   rst_in,
   lebs_stream_if.snk  wr,
   lebs_stream_if.src  rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic [W-1:0]  dout_r;
   logic          ov_r;
   wire           push;
   wire           load;

   // ===========================================================
   // handshakes
   // room leaves space for words already in the sampling pipe
   assign push     = wr.valid && wr.ready;
   assign load     = (cnt_r != '0) && (!ov_r || rd.ready);
   assign wr.ready = cnt_r < (AW+1)'(DEPTH);
   assign wr.room  = cnt_r <= (AW+1)'(DEPTH - 1 - SLACK);
   assign rd.valid = ov_r;
   assign rd.data  = dout_r;

   // storage array carries no reset
   always_ff @(posedge clock_in) begin
      if (push) begin
         mem_r[wp_r] <= wr.data;
      end
   end

   // pointers and count
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= push ? wp_r + 1'b1 : wp_r;
         rp_r  <= load ? rp_r + 1'b1 : rp_r;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // output register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ov_r   <= 1'b0;
         dout_r <= '0;
      end else if (load) begin
         ov_r   <= 1'b1;
         dout_r <= mem_r[rp_r];
      end else if (rd.ready) begin
         ov_r   <= 1'b0;
      end
   end
endmodule

// [hw/lebs_top.sv]
// local external bus sequencer: chip select, strobe and beat timing
`include "lebs_params.svh"

module lebs_top
   import lebs_pkg::*;
#(
   parameter int CS_NUM = `LEBS_CS_NUM,
   parameter int AW     = `LEBS_ADDR_W,
   parameter int AHW    = `LEBS_ADDR_HI_W,
   parameter int DW     = `LEBS_DATA_W,
   parameter int DCW    = `LEBS_DC_W,
   parameter int DEPTH  = `LEBS_FIFO_DEPTH
) (
   input  wire logic                  clock_in,
   input  wire logic                  rst_in,
   input  wire logic                  req_valid_in,
   output logic                       req_ready_out,
   input  wire logic                  req_write_in,
   input  wire logic [AW-1:0]         req_addr_in,
   input  wire logic [DW-1:0]         req_wdata_in,
   input  wire logic [2:0]            req_cs_in,
   input  wire logic [1:0]            req_tsize_in,
   input  wire logic                  req_source_burst_in,
   input  wire logic [1:0]            mode_in,
   input  wire logic                  large_flash_mode_in,
   input  wire logic                  graphics_bus_mode_in,
   input  wire logic [7:0]            wait_count_primary_in,
   input  wire logic [7:0]            wait_count_extra_in,
   input  wire logic [DCW-1:0]        dead_cycle_count_in,
   input  wire logic [1:0]            data_size_in,
   input  wire logic [2*CS_NUM-1:0]   burst_read_write_enable_in,
   input  wire logic [CS_NUM-1:0]     long_burst_select_in,
   input  wire logic                  arb_handover_in,
   output logic [CS_NUM-1:0]          cs_n_out,
   output logic                       oe_n_out,
   output logic                       rw_out,
   output logic                       rw_oe_n_out,
   output logic                       ale_out,
   output logic                       transfer_start_strobe_out,
   output logic [1:0]                 transfer_size_out,
   output logic                       transfer_size_oe_n_out,
   output logic [AW-1:0]              addr_out,
   output logic                       addr_oe_n_out,
   output logic                       addr_hi_oe_n_out,
   output logic [DW-1:0]              data_out,
   output logic                       data_oe_n_out,
   input  wire logic [DW-1:0]         data_in,
   input  wire logic                  ack_in,
   output logic                       ack_out,
   output logic                       ack_oe_n_out,
   output logic                       busy_out,
   output logic                       rd_valid_out,
   input  wire logic                  rd_ready_in,
   output logic [DW-1:0]              rd_data_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   // decoded chip select, one bit per select line
   function automatic logic [CS_NUM-1:0] lebs_onehot(input logic [2:0] s);
      lebs_onehot = CS_NUM'(1) << s;
   endfunction

   // beats per cache line: 4^lb * 2 * (32 / bus width)
   function automatic logic [5:0] lebs_beats(input logic lb,
                                            input logic [1:0] dsz);
      logic [5:0] base;
      base = lb ? `LEBS_BEATS_LONG : `LEBS_BEATS_SHORT;
      lebs_beats = base >> dsz;
   endfunction

   // ===========================================================
   // state and latched request
   lebs_state_e           state_r;
   lebs_state_e           state_nxt;
   lebs_mode_e            mode_r;
   logic                  wr_r;
   logic [AW-1:0]         addr_r;
   logic [DW-1:0]         wdata_r;
   logic [2:0]            csel_r;
   logic [1:0]            tsize_r;
   logic                  flash_r;
   logic                  gfx_r;
   logic [15:0]           ws_r;
   logic [DCW-1:0]        dc_r;
   logic [5:0]            beats_r;
   logic [16:0]           cnt_r;
   logic [5:0]            beat_r;
   logic [DCW-1:0]        dead_r;
   logic [DW-1:0]         data_r;
   logic                  ack_s1_r;
   logic                  ack_s2_r;
   logic [DW-1:0]         din_s1_r;
   logic [DW-1:0]         din_s2_r;
   logic                  cap1_r;
   logic                  cap2_r;

   // ===========================================================
   // decode
   wire        fifo_room;
   wire        accept;
   wire        is_burst  = mode_r == MODE_BURST;
   wire        is_mux    = mode_r == MODE_MUX;
   wire        ts_mode   = flash_r || gfx_r;
   wire        cs_active = (state_r == ST_WAIT) || (state_r == ST_BEAT);
   wire        span      = (state_r != ST_IDLE) && (state_r != ST_DEAD);
   wire        beat_go   = wr_r || fifo_room;
   wire        wait_done = cnt_r == 17'h0_0000;
   wire [15:0] ws_in     = {wait_count_extra_in, wait_count_primary_in};
   wire [1:0]  bre_sel   = burst_read_write_enable_in[{req_cs_in, 1'b0} +: 2];
   wire        lb_in     = (bre_sel == 2'b11) && req_source_burst_in
                           && long_burst_select_in[req_cs_in];
   wire        early_ack = !is_burst && ack_s2_r;
   wire        cap0      = !wr_r && ((state_r == ST_WAIT && !is_burst &&
                           (wait_done || early_ack)) ||
                           (state_r == ST_BEAT && beat_go));

   // reads start only when the fifo can take the words in flight
   assign accept        = req_valid_in && req_ready_out;
   assign req_ready_out = (state_r == ST_IDLE) && (req_write_in || fifo_room);
   assign busy_out      = state_r != ST_IDLE;

   // ===========================================================
   // next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  if (accept) begin
            state_nxt = ST_SETUP;
         end
         ST_SETUP: state_nxt = is_mux ? ST_ALE : ST_WAIT;
         ST_ALE:   state_nxt = ST_WAIT;
         ST_WAIT:  if (is_burst && wait_done) begin
            state_nxt = ST_BEAT;
         end else if (!is_burst && (wait_done || early_ack)) begin
            state_nxt = ST_HOLD;
         end
         ST_BEAT:  if (beat_r == 6'h01 && beat_go) begin
            state_nxt = ST_HOLD;
         end
         ST_HOLD:  if (arb_handover_in || dc_r == '0) begin
            state_nxt = ST_IDLE;
         end else begin
            state_nxt = ST_DEAD;
         end
         ST_DEAD:  if (arb_handover_in || dead_r == DCW'(1)) begin
            state_nxt = ST_IDLE;
         end
         default:  state_nxt = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ===========================================================
   // request capture; configuration is frozen for the whole access
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         mode_r  <= MODE_SINGLE;
         wr_r    <= 1'b0;
         addr_r  <= '0;
         wdata_r <= '0;
         csel_r  <= 3'h0;
         tsize_r <= 2'h0;
         flash_r <= 1'b0;
         gfx_r   <= 1'b0;
         ws_r    <= 16'h0000;
         dc_r    <= '0;
         beats_r <= 6'h00;
      end else if (accept) begin
         mode_r  <= (mode_in == 2'b11) ? MODE_SINGLE : lebs_mode_e'(mode_in);
         wr_r    <= req_write_in;
         addr_r  <= req_addr_in;
         wdata_r <= req_wdata_in;
         csel_r  <= req_cs_in;
         tsize_r <= req_tsize_in;
         flash_r <= large_flash_mode_in;
         gfx_r   <= graphics_bus_mode_in;
         ws_r    <= ws_in;
         dc_r    <= dead_cycle_count_in;
         beats_r <= lebs_beats(lb_in, data_size_in);
      end
   end

   // ===========================================================
   // wait, beat and dead counters
   // single: ws+1 down to 0 gives 2+ws selects; burst: ws gives 1+ws
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cnt_r <= 17'h0_0000;
      end else if (state_nxt == ST_WAIT && state_r != ST_WAIT) begin
         cnt_r <= is_burst ? {1'b0, ws_r} : {1'b0, ws_r} + 17'h0_0001;
      end else if (state_r == ST_WAIT && !wait_done) begin
         cnt_r <= cnt_r - 17'h0_0001;
      end
   end

   // beat counter stalls on reads while the fifo is short of room
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         beat_r <= 6'h00;
      end else if (state_nxt == ST_BEAT && state_r != ST_BEAT) begin
         beat_r <= beats_r;
      end else if (state_r == ST_BEAT && beat_go) begin
         beat_r <= beat_r - 6'h01;
      end
   end

   // dead cycles keep the bus parked after the select negates
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         dead_r <= '0;
      end else if (state_r == ST_HOLD) begin
         dead_r <= dc_r;
      end else if (state_r == ST_DEAD) begin
         dead_r <= dead_r - DCW'(1);
      end
   end

   // ===========================================================
   // pin synchronisers; second stage is the only reader of the first
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         din_s1_r <= `LEBS_RST_DATA;
         din_s2_r <= `LEBS_RST_DATA;
      end else begin
         ack_s1_r <= ack_in;
         ack_s2_r <= ack_s1_r;
         din_s1_r <= data_in;
         din_s2_r <= din_s1_r;
      end
   end

   // capture tag follows the data through the same two stages
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cap1_r <= 1'b0;
         cap2_r <= 1'b0;
      end else begin
         cap1_r <= cap0;
         cap2_r <= cap1_r;
      end
   end

   // ===========================================================
   // data lines: address phase in mux latch cycle, else write data
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         data_r <= `LEBS_RST_DATA;
      end else if (state_nxt == ST_ALE) begin
         data_r <= DW'({tsize_r, 4'h0, addr_r});
      end else begin
         data_r <= wdata_r;
      end
   end

   // ===========================================================
   // bus pin decode
   wire nm_data = !is_mux && span;
   wire mx_data = is_mux && (cs_active || state_r == ST_HOLD);
   wire hi_span = (state_r == ST_SETUP) || cs_active;

   assign cs_n_out = cs_active ? ~lebs_onehot(csel_r)
                               : {CS_NUM{1'b1}};
   assign oe_n_out      = !(cs_active && !wr_r);
   assign rw_out        = !wr_r;
   assign rw_oe_n_out   = !span;
   assign ale_out       = state_r == ST_ALE;
   assign transfer_start_strobe_out = ts_mode &&
      (is_mux ? state_r == ST_ALE : state_r == ST_SETUP);
   assign transfer_size_out      = tsize_r;
   assign transfer_size_oe_n_out = !(gfx_r && span);
   assign addr_out         = addr_r;
   assign addr_oe_n_out    = !(span && !is_mux);
   // upper lines are shared pins: freed with the select in flash or graphics bus mode
   assign addr_hi_oe_n_out = ts_mode ? !(hi_span && !is_mux)
                                     : addr_oe_n_out;
   assign data_out      = data_r;
   assign data_oe_n_out = !(ale_out || (wr_r && (nm_data || mx_data)));
   assign ack_out       = (state_r == ST_BEAT) && beat_go;
   assign ack_oe_n_out  = !(is_burst && cs_active);

   // ===========================================================
   // read data fifo
   lebs_stream_if #(.W(DW)) fill_if ();
   lebs_stream_if #(.W(DW)) drain_if ();

   assign fill_if.valid  = cap2_r;
   assign fill_if.data   = din_s2_r;
   assign fifo_room      = fill_if.room && fill_if.ready;
   assign drain_if.ready = rd_ready_in;
   assign drain_if.room  = rd_ready_in;
   assign rd_valid_out   = drain_if.valid;
   assign rd_data_out    = drain_if.data;

   lebs_fifo #(
      .W     (DW),
      .DEPTH (DEPTH),
      .SLACK (`LEBS_SYNC_SLACK)
   ) u_fifo (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .wr       (fill_if),
      .rd       (drain_if)
   );

   // ===========================================================
   // assertion helpers: select and acknowledge lengths per access
   logic [17:0] cs_len_r;
   logic [5:0]  ack_len_r;
   logic        ack_seen_r;
   logic        stall_r;

   always_ff @(posedge clock_in) begin
      if (rst_in || state_r == ST_IDLE) begin
         cs_len_r   <= 18'h0_0000;
         ack_len_r  <= 6'h00;
         ack_seen_r <= 1'b0;
         stall_r    <= 1'b0;
      end else begin
         cs_len_r   <= cs_active ? cs_len_r + 18'h0_0001 : cs_len_r;
         ack_len_r  <= ack_out ? ack_len_r + 6'h01 : ack_len_r;
         ack_seen_r <= ack_seen_r || (state_r == ST_WAIT && early_ack);
         stall_r    <= stall_r || (state_r == ST_BEAT && !beat_go);
      end
   end

   // ===========================================================
   // assertions
   property p_single_width;
      $fell(cs_active) && !is_burst && !ack_seen_r |->
         cs_len_r == {2'h0, ws_r} + 18'h0_0002;
   endproperty
   a_single_width: assert property (p_single_width)
      else $error("single select width wrong");

   property p_early_ack;
      state_r == ST_WAIT && !is_burst && ack_s2_r |=> !cs_active;
   endproperty
   a_early_ack: assert property (p_early_ack)
      else $error("acknowledge did not end access");

   property p_burst_width;
      $fell(cs_active) && is_burst && !stall_r |->
         cs_len_r == {2'h0, ws_r} + 18'h0_0001 + 18'(beats_r)
         && ack_len_r == beats_r;
   endproperty
   a_burst_width: assert property (p_burst_width)
      else $error("burst select or beat width wrong");

   property p_ack_start;
      $rose(ack_out) && is_burst |-> cs_len_r == {2'h0, ws_r} + 18'h0_0001;
   endproperty
   a_ack_start: assert property (p_ack_start)
      else $error("burst acknowledge late");

   property p_ack_drive;
      ack_out |-> !ack_oe_n_out && is_burst;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("acknowledge driven outside burst");

   property p_handover;
      state_r == ST_HOLD && arb_handover_in |=> state_r == ST_IDLE;
   endproperty
   a_handover: assert property (p_handover)
      else $error("dead cycles used on handover");

   property p_ts_pulse;
      $rose(transfer_start_strobe_out) |->
         ts_mode ##1 (!transfer_start_strobe_out && cs_active);
   endproperty
   a_ts_pulse: assert property (p_ts_pulse)
      else $error("start strobe wrong");

   property p_ale_then_cs;
      ale_out |-> !rw_oe_n_out ##1 (!ale_out && cs_active);
   endproperty
   a_ale_then_cs: assert property (p_ale_then_cs)
      else $error("latch strobe not followed by select");

   property p_rw_around_cs;
      $changed(cs_active) |-> !$past(rw_oe_n_out) && !rw_oe_n_out;
   endproperty
   a_rw_around_cs: assert property (p_rw_around_cs)
      else $error("rw not held around select");

   property p_oe_read;
      !oe_n_out |-> cs_active && !wr_r;
   endproperty
   a_oe_read: assert property (p_oe_read)
      else $error("output enable outside read select");

   c_single_read: cover property (state_r == ST_HOLD && !wr_r && !is_burst);
   c_burst_read: cover property ($fell(cs_active) && is_burst && !wr_r);
   c_mux_write: cover property (ale_out && wr_r);
   c_early_ack: cover property (state_r == ST_WAIT && early_ack);
endmodule

// [tb/lebs_mem_model.sv]
// behavioural external flash or sram facing the sequencer pins
module lebs_mem_model (
   input  wire logic        clock_in,
   input  wire logic [7:0]  cs_n_in,
   input  wire logic        rw_in,
   input  wire logic        data_oe_n_in,
   input  wire logic [25:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic [7:0]  ack_dly_in,
   output logic      [31:0] rdata_out,
   output logic             ack_out,
   output logic      [31:0] last_wr_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        sel;
   logic [7:0]  sel_cnt = 8'h00;
   logic [31:0] word;
   logic [31:0] junk = 32'h0000_0000;
   initial ack_out = 1'b0;
   initial last_wr_out = 32'h0000_0000;
   // ==========================================================
   // read path: released lines toggle so a stale sample cannot match
   assign sel = (cs_n_in != 8'hff);
   assign word = {addr_in[15:0], ~addr_in[15:0]};
   assign rdata_out = (sel && rw_in) ? word : junk;
   // early acknowledge after ack_dly_in selected cycles, zero means never
   always @(posedge clock_in) begin
      sel_cnt <= sel ? sel_cnt + 8'h01 : 8'h00;
      ack_out <= sel && (ack_dly_in != 8'h00) &&
                 (sel_cnt + 8'h01 >= ack_dly_in);
      // unknown select before the first reset edge must not poison junk
      junk <= (sel === 1'b1 && rw_in === 1'b1) ? ~word : ~junk;
      if (sel && !rw_in && !data_oe_n_in)
         last_wr_out <= wdata_in;
   end
endmodule

// [tb/local_external_bus_sequencer_test.sv]
// self-checking bench for the local external bus sequencer
module local_external_bus_sequencer_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // design pins
   logic clock_in, rst_in, req_valid_in, req_write_in, req_source_burst_in;
   logic large_flash_mode_in, graphics_bus_mode_in, arb_handover_in;
   logic rd_ready_in, req_ready_out, oe_n_out, rw_out, rw_oe_n_out, ale_out;
   logic transfer_start_strobe_out, transfer_size_oe_n_out, addr_oe_n_out;
   logic addr_hi_oe_n_out, data_oe_n_out, ack_in, ack_out, ack_oe_n_out;
   logic busy_out, rd_valid_out;
   logic [1:0]  req_tsize_in, mode_in, data_size_in, transfer_size_out;
   logic [2:0]  req_cs_in;
   logic [3:0]  dead_cycle_count_in;
   logic [7:0]  wait_count_primary_in, wait_count_extra_in;
   logic [7:0]  long_burst_select_in, cs_n_out, ack_dly;
   logic [15:0] burst_read_write_enable_in;
   logic [25:0] req_addr_in, addr_out;
   logic [31:0] req_wdata_in, data_out, data_in, rd_data_out, last_wr;
   int          err_total = 0;
   int          cmp_count = 0;
   typedef struct {
      int md, wr, ws, dsz, en, src, fl, gf, dc, hov, akd;
      int e_cs, e_ack, e_ts, e_ale, e_tail, e_wd;
   } lebs_row_s;
   lebs_row_s   rows [8];
   lebs_top lebs_top_inst (
      .clock_in, .rst_in, .req_valid_in, .req_ready_out, .req_write_in,
      .req_addr_in, .req_wdata_in, .req_cs_in, .req_tsize_in,
      .req_source_burst_in, .mode_in, .large_flash_mode_in,
      .graphics_bus_mode_in, .wait_count_primary_in, .wait_count_extra_in,
      .dead_cycle_count_in, .data_size_in, .burst_read_write_enable_in,
      .long_burst_select_in, .arb_handover_in, .cs_n_out, .oe_n_out, .rw_out,
      .rw_oe_n_out, .ale_out, .transfer_start_strobe_out, .transfer_size_out,
      .transfer_size_oe_n_out, .addr_out, .addr_oe_n_out, .addr_hi_oe_n_out,
      .data_out, .data_oe_n_out, .data_in, .ack_in, .ack_out, .ack_oe_n_out,
      .busy_out, .rd_valid_out, .rd_ready_in, .rd_data_out
   );
   lebs_mem_model lebs_mem_model_inst (
      .clock_in, .cs_n_in(cs_n_out), .rw_in(rw_out),
      .data_oe_n_in(data_oe_n_out), .addr_in(addr_out),
      .wdata_in(data_out), .ack_dly_in(ack_dly), .rdata_out(data_in),
      .ack_out(ack_in), .last_wr_out(last_wr)
   );
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   // ==========================================================
   // shared tasks
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // request held from a falling edge until the design takes it
   task automatic issue(lebs_row_s r, int c);
      int n;
      @(negedge clock_in);
      mode_in = r.md[1:0];
      req_write_in = r.wr[0];
      wait_count_primary_in = r.ws[7:0];
      wait_count_extra_in = r.ws[15:8];
      data_size_in = r.dsz[1:0];
      burst_read_write_enable_in = r.en ? 16'h0003 << (2 * c) : 16'h0000;
      long_burst_select_in = r.en ? 8'h01 << c : 8'h00;
      req_source_burst_in = r.src[0];
      large_flash_mode_in = r.fl[0];
      graphics_bus_mode_in = r.gf[0];
      dead_cycle_count_in = r.dc[3:0];
      arb_handover_in = r.hov[0];
      ack_dly = r.akd[7:0];
      req_cs_in = c[2:0];
      req_tsize_in = c[1:0];
      req_addr_in = {23'h091a00, c[2:0]};
      req_wdata_in = {8'hc3, req_addr_in[23:0]};
      req_valid_in = 1'b1;
      for (n = 0; n < 50 && req_ready_out !== 1'b1; n++) @(negedge clock_in);
      if (n == 50) begin
         err_total++;
         close_out();
      end
      @(negedge clock_in);
      req_valid_in = 1'b0;
   endtask
   // one access, watched at every falling edge until long idle
   task automatic run(lebs_row_s r, int c);
      int csw = 0, ack = 0, ts = 0, ale = 0, tail = 0, wd = 0, obad = 0;
      int idle = 0, apos = 0, n, aoe = 0, koe = 0;
      logic pcs = 1'b0, prw = 1'b1, csl, rwpre = 1'b0, rwpost = 1'b0;
      logic tz = 1'b0, hirel = 1'b0;
      logic [7:0] sel = 8'hff, esel;
      logic [31:0] w0 = 32'h0000_0000, ew;
      esel = ~(8'h01 << c);
      issue(r, c);
      ew = {req_addr_in[15:0], ~req_addr_in[15:0]};
      for (n = 0; n < 300 && idle < 6; n++) begin
         csl = (cs_n_out !== 8'hff);
         if (csl) begin
            csw++;
            sel = cs_n_out;
            if (transfer_size_oe_n_out === 1'b0) tz = 1'b1;
         end
         if (ack_out === 1'b1 && ack == 0) apos = csw;
         ack += (ack_out === 1'b1);
         ts += (transfer_start_strobe_out === 1'b1);
         ale += (ale_out === 1'b1);
         aoe += (addr_oe_n_out === 1'b0);
         koe += (ack_oe_n_out === 1'b0);
         tail += (!csl && csw > 0 && busy_out === 1'b1);
         obad += (oe_n_out !== 1'b1 && (!csl || r.wr != 0));
         if (csl && !pcs) rwpre = !prw;
         if (!csl && pcs) begin
            rwpost = (rw_oe_n_out === 1'b0);
            hirel = addr_hi_oe_n_out;
         end
         if (rd_valid_out === 1'b1) begin
            if (wd == 0) w0 = rd_data_out;
            wd++;
         end
         idle += (busy_out === 1'b0);
         pcs = csl;
         prw = rw_oe_n_out;
         @(negedge clock_in);
      end
      if (n == 300) begin
         err_total++;
         close_out();
      end
      if (r.akd) check("cs short", csw < r.e_cs, 1);
      else check("cs width", csw, r.e_cs);
      check("ack beats", ack, r.e_ack);
      check("ack driven", koe, r.md == 1 ? r.e_cs : 0);
      check("addr driven", aoe, r.md == 2 ? 0 : csw + 2);
      if (r.md == 1) check("ack start", apos, r.ws + 2);
      check("start strobe", ts, r.e_ts);
      check("latch strobe", ale, r.e_ale);
      check("tail", tail, r.e_tail);
      check("words", wd, r.e_wd);
      check("select", sel, esel);
      check("oe outside read", obad, 0);
      check("rw before", rwpre, 1);
      check("rw after", rwpost, 1);
      check("size driven", tz, r.gf);
      if (r.gf) check("size value", transfer_size_out, c[1:0]);
      if (r.fl) check("upper release", hirel, 1);
      if (r.md == 0 && r.wr == 0) check("read word", w0, ew);
      if (r.wr) check("write word", last_wr, req_wdata_in);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      int i, wd;
      rst_in = 1'b1;
      req_valid_in = 1'b0;
      rd_ready_in = 1'b1;
      issue_defaults();
      rows[0] = '{0,0,0,2,0,0,0,0,0,0,0,2,0,0,0,1,1};
      rows[1] = '{0,1,3,2,0,0,1,0,2,0,0,5,0,1,0,3,0};
      rows[2] = '{2,1,1,2,0,0,0,1,0,0,0,3,0,1,1,1,0};
      rows[3] = '{2,0,0,2,0,0,0,0,1,1,0,2,0,0,1,1,1};
      rows[4] = '{1,0,2,2,0,0,0,0,0,0,0,5,2,0,0,1,2};
      rows[5] = '{1,0,1,0,1,1,0,0,0,0,0,34,32,0,0,1,32};
      rows[6] = '{1,0,0,1,1,0,0,0,0,0,0,5,4,0,0,1,4};
      rows[7] = '{0,0,10,2,0,0,0,0,0,0,2,12,0,0,0,1,1};
      repeat (2) @(negedge clock_in);
      rst_in = 1'b0;
      for (i = 0; i < 8; i++) run(rows[i], i);
      // stalled consumer: reads are refused once the fifo runs short
      rd_ready_in = 1'b0;
      for (i = 0; i < 8 && req_ready_out === 1'b1; i++) begin
         issue(rows[0], i);
         repeat (8) @(negedge clock_in);
      end
      // six words sit in the array and one in the output register
      check("reads taken", i, 7);
      rd_ready_in = 1'b1;
      wd = 0;
      for (i = 0; i < 10; i++) begin
         wd += (rd_valid_out === 1'b1);
         @(negedge clock_in);
      end
      check("drained", wd, 7);
      check("empty", rd_valid_out, 0);
      // reset in the middle of a long burst, then a plain access
      issue(rows[5], 5);
      repeat (5) @(negedge clock_in);
      rst_in = 1'b1;
      repeat (2) @(negedge clock_in);
      check("reset select", cs_n_out, 8'hff);
      check("reset flags",
            {busy_out, req_ready_out, rd_valid_out, ack_out, oe_n_out}, 5'h09);
      rst_in = 1'b0;
      run(rows[0], 0);
      close_out();
   end
   // time-zero values for every request-side input except req_valid_in
   task automatic issue_defaults();
      {req_write_in, req_source_burst_in, large_flash_mode_in} = 3'h0;
      {graphics_bus_mode_in, arb_handover_in} = 2'h0;
      {req_tsize_in, mode_in, data_size_in, req_cs_in} = 9'h000;
      {dead_cycle_count_in, wait_count_primary_in, wait_count_extra_in} = 20'h0;
      {long_burst_select_in, burst_read_write_enable_in, ack_dly} = 32'h0;
      {req_addr_in, req_wdata_in} = 58'h0;
   endtask
endmodule
